// [cgirq_consts.vh]
`ifndef CGIRQ_CONSTS_VH
`define CGIRQ_CONSTS_VH

// Register offsets on the serial port
`define CGIRQ_ADDR_LATCH    8'hd0
`define CGIRQ_ADDR_MASK     8'hd1
`define CGIRQ_ADDR_STATUS   8'hd2
`define CGIRQ_ADDR_STATE    8'hd3
`define CGIRQ_ADDR_CONTROL  8'hd4

// Reset values
`define CGIRQ_RST_LATCH     8'h00
`define CGIRQ_RST_MASK      8'h00
`define CGIRQ_RST_STATUS    8'h00
`define CGIRQ_RST_STATE     8'h00
`define CGIRQ_RST_CONTROL   8'ha1

// Writable bits of mask and control (reserved bits stay zero)
`define CGIRQ_WMASK_MASK    8'hfe
`define CGIRQ_WMASK_CONTROL 8'hef

// Condition bit positions shared by latch, mask and status
`define CGIRQ_BIT_BATOVP    1
`define CGIRQ_BIT_TEMP      2
`define CGIRQ_BIT_COMP      3
`define CGIRQ_BIT_INDET     4
`define CGIRQ_BIT_BATTERY_DETECT_EVENT    5
`define CGIRQ_BIT_CURLIM    6
`define CGIRQ_BIT_INOVP     7

// Control bit positions
`define CGIRQ_CTL_ENABLE_N  0
`define CGIRQ_CTL_TRICKLE   1
`define CGIRQ_CTL_WATCHDOG  2
`define CGIRQ_CTL_STSEL     3

// Serial frame: write flag, 8 address bits, 8 data bits
`define CGIRQ_FRAME_BITS    5'h11
`define CGIRQ_ADDR_DONE     5'h08
`define CGIRQ_LAST_BIT      5'h10
`define CGIRQ_DATA_FIRST    5'h09

`endif

// [cgirq_sync.v]
`timescale 1ns/1ps
module cgirq_sync #(
    parameter W = 1
) (
    input  wire         mclk,
    input  wire         rst,
    input  wire         ce,
    input  wire [W-1:0] async,
    output wire [W-1:0] synced
);
    reg [W-1:0] stage1_q;
    reg [W-1:0] stage2_q;

    // Two flops; only the second stage is seen outside
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            stage1_q <= {W{1'b0}};
            stage2_q <= {W{1'b0}};
        end else if (ce) begin
            stage1_q <= async;
            stage2_q <= stage1_q;
        end
    end

    assign synced = stage2_q;
endmodule

// [cgirq_spi_port.v]
`timescale 1ns/1ps
`include "cgirq_consts.vh"
module cgirq_spi_port (
    input  wire       mclk,
    input  wire       rst,
    input  wire       ce,
    input  wire       sclkS,
    input  wire       csNS,
    input  wire       mosiS,
    input  wire [7:0] rdData,
    output wire [7:0] regAddr,
    output wire       rdStrobe,
    output wire       wrEn,
    output wire [7:0] wrData,
    output wire       miso,
    output wire       misoOe
);
    reg        sclkPrev_q;
    reg [4:0]  bitCnt_q;
    reg [7:0]  shift_q;
    reg [7:0]  addr_q;
    reg        isWrite_q;
    reg        addrValid_q;
    reg        wrEn_q;
    reg [7:0]  wrData_q;
    reg [7:0]  rdShift_q;
    reg        miso_q;
    wire       sclkRise;
    wire       sclkFall;

    // Edges seen on the oversampled clock; sclk must run well below mclk/4
    assign sclkRise = sclkS & ~sclkPrev_q;
    assign sclkFall = ~sclkS & sclkPrev_q;

    // Frame capture, mode 0: sample on rise, drive on fall
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            sclkPrev_q  <= 1'b0;
            bitCnt_q    <= 5'h00;
            shift_q     <= 8'h00;
            addr_q      <= 8'h00;
            isWrite_q   <= 1'b0;
            addrValid_q <= 1'b0;
            wrEn_q      <= 1'b0;
            wrData_q    <= 8'h00;
            rdShift_q   <= 8'h00;
            miso_q      <= 1'b0;
        end else if (ce) begin
            sclkPrev_q  <= sclkS;
            addrValid_q <= 1'b0;
            wrEn_q      <= 1'b0;
            if (csNS) begin
                bitCnt_q <= 5'h00;
                miso_q   <= 1'b0;
            end else begin
                if (sclkRise && bitCnt_q != `CGIRQ_FRAME_BITS) begin
                    shift_q  <= {shift_q[6:0], mosiS};
                    bitCnt_q <= bitCnt_q + 5'h01;
                    if (bitCnt_q == 5'h00) begin
                        isWrite_q <= mosiS;
                    end
                    if (bitCnt_q == `CGIRQ_ADDR_DONE) begin
                        addr_q      <= {shift_q[6:0], mosiS};
                        addrValid_q <= 1'b1;
                    end
                    if (bitCnt_q == `CGIRQ_LAST_BIT) begin
                        wrData_q <= {shift_q[6:0], mosiS};
                        wrEn_q   <= isWrite_q;
                    end
                end
                // Read data loaded one cycle after the address completes
                if (addrValid_q) begin
                    rdShift_q <= rdData;
                end else if (sclkFall && bitCnt_q >= `CGIRQ_DATA_FIRST
                             && bitCnt_q <= `CGIRQ_LAST_BIT) begin
                    miso_q    <= rdShift_q[7];
                    rdShift_q <= {rdShift_q[6:0], 1'b0};
                end
            end
        end
    end

    assign regAddr  = addr_q;
    assign rdStrobe = addrValid_q & ~isWrite_q;
    assign wrEn     = wrEn_q;
    assign wrData   = wrData_q;
    assign miso     = miso_q;
    assign misoOe   = ~csNS;
endmodule

// [cgirq_top.v]
`timescale 1ns/1ps
`include "cgirq_consts.vh"
module cgirq_top (
    input  wire       mclk,
    input  wire       rst,
    input  wire       ce,
    input  wire       spiSclk,
    input  wire       spiCs_n,
    input  wire       spiMosi,
    output wire       spiMiso,
    output wire       spiMisoOe,
    input  wire       batteryOvervoltage,
    input  wire       temperatureFault,
    input  wire       chargeComplete,
    input  wire       inputPresent,
    input  wire       batteryPresent,
    input  wire       currentLimit,
    input  wire       inputOvervoltage,
    input  wire [3:0] chargerStateCode,
    output wire       chargerEnable_n,
    output wire       trickleForce,
    output wire       watchdogEnable,
    output wire       stateUpdateSelect,
    output wire [2:0] controlUpper,
    output wire       chargerIrq
);
    wire [2:0]  pinSync;
    wire [10:0] condSync;
    wire [7:0]  regAddr;
    wire        rdStrobe;
    wire        wrEn;
    wire [7:0]  wrData;
    reg  [7:0]  rdData;

    wire [7:0]  cond;
    wire [3:0]  stateCode;
    reg  [7:0]  condPrev_q;
    reg  [3:0]  statePrev_q;
    reg         primed_q;
    reg  [7:0]  mask_q;
    reg  [7:0]  ctrl_q;
    reg  [7:0]  latch_q;
    reg  [7:0]  latch_d;
    reg         stChg_q;
    reg         stChg_d;
    reg         irq_q;
    wire        stateChanged;
    wire [7:0]  condRise;
    wire [7:0]  condEdge;
    reg  [7:0]  events;
    wire [7:0]  status;
    wire        stSel;

    // Serial pins come from another clock domain
    cgirq_sync #(
        .W (3)
    ) u_pinSync (
        .mclk   (mclk),
        .rst    (rst),
        .ce     (ce),
        .async  ({spiSclk, spiCs_n, spiMosi}),
        .synced (pinSync)
    );

    // Analogue comparators and state code are asynchronous too
    cgirq_sync #(
        .W (11)
    ) u_condSync (
        .mclk   (mclk),
        .rst    (rst),
        .ce     (ce),
        .async  ({chargerStateCode, inputOvervoltage, currentLimit,
                  batteryPresent, inputPresent, chargeComplete,
                  temperatureFault, batteryOvervoltage}),
        .synced (condSync)
    );

    cgirq_spi_port u_spi (
        .mclk     (mclk),
        .rst      (rst),
        .ce       (ce),
        .sclkS    (pinSync[2]),
        .csNS     (pinSync[1]),
        .mosiS    (pinSync[0]),
        .rdData   (rdData),
        .regAddr  (regAddr),
        .rdStrobe (rdStrobe),
        .wrEn     (wrEn),
        .wrData   (wrData),
        .miso     (spiMiso),
        .misoOe   (spiMisoOe)
    );

    // Condition vector in register bit order, bit 0 reserved
    assign cond      = {condSync[6:0], 1'b0};
    assign stateCode = condSync[10:7];
    assign stSel     = ctrl_q[`CGIRQ_CTL_STSEL];

    // Edge detection against last cycle's conditions
    assign condRise     = cond & ~condPrev_q;
    assign condEdge     = cond ^ condPrev_q;
    assign stateChanged = primed_q && (stateCode != statePrev_q);

    // History; first cycle after reset only loads it; levels present at the pins at release
    // reach cond two cycles later through the synchronisers and still raise events
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            condPrev_q  <= 8'h00;
            statePrev_q <= 4'h0;
            primed_q    <= 1'b0;
        end else if (ce) begin
            condPrev_q  <= cond;
            statePrev_q <= stateCode;
            primed_q    <= 1'b1;
        end
    end

    // Events that set the latch
    always @* begin
        events = 8'h00;
        if (primed_q) begin
            events[`CGIRQ_BIT_BATOVP] = condRise[`CGIRQ_BIT_BATOVP];
            events[`CGIRQ_BIT_TEMP]   = condRise[`CGIRQ_BIT_TEMP];
            // Completion source follows the select bit
            if (stSel) begin
                events[`CGIRQ_BIT_COMP] = stateChanged;
            end else begin
                events[`CGIRQ_BIT_COMP] = condRise[`CGIRQ_BIT_COMP];
            end
            events[`CGIRQ_BIT_INDET]  = condEdge[`CGIRQ_BIT_INDET];
            events[`CGIRQ_BIT_BATTERY_DETECT_EVENT] = condEdge[`CGIRQ_BIT_BATTERY_DETECT_EVENT];
            events[`CGIRQ_BIT_CURLIM] = condRise[`CGIRQ_BIT_CURLIM];
            events[`CGIRQ_BIT_INOVP]  = condRise[`CGIRQ_BIT_INOVP];
        end
    end

    // Latch clears on read; a same-cycle event wins over the clear
    always @* begin
        latch_d = latch_q;
        if (rdStrobe && regAddr == `CGIRQ_ADDR_LATCH) begin
            latch_d = 8'h00;
        end
        latch_d = (latch_d | events) & 8'hfe;
    end

    // State-change flag for status bit 3, cleared by a status read
    always @* begin
        stChg_d = stChg_q;
        if (rdStrobe && regAddr == `CGIRQ_ADDR_STATUS) begin
            stChg_d = 1'b0;
        end
        // Only counted while selected, so no stale flag shows on switching
        if (stateChanged && stSel) begin
            stChg_d = 1'b1;
        end
    end

    // Live status; only bit 3 may carry a flag
    assign status = {cond[`CGIRQ_BIT_INOVP],
                     cond[`CGIRQ_BIT_CURLIM],
                     cond[`CGIRQ_BIT_BATTERY_DETECT_EVENT],
                     cond[`CGIRQ_BIT_INDET],
                     stSel ? stChg_q : cond[`CGIRQ_BIT_COMP],
                     cond[`CGIRQ_BIT_TEMP],
                     cond[`CGIRQ_BIT_BATOVP],
                     1'b0};

    // Software registers, latch and interrupt output
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            mask_q  <= `CGIRQ_RST_MASK;
            ctrl_q  <= `CGIRQ_RST_CONTROL;
            latch_q <= `CGIRQ_RST_LATCH;
            stChg_q <= 1'b0;
            irq_q   <= 1'b0;
        end else if (ce) begin
            latch_q <= latch_d;
            stChg_q <= stChg_d;
            // Masked bits kept out of the interrupt only
            irq_q   <= |(latch_d & ~mask_q);
            if (wrEn) begin
                if (regAddr == `CGIRQ_ADDR_MASK) begin
                    mask_q <= wrData & `CGIRQ_WMASK_MASK;
                end else if (regAddr == `CGIRQ_ADDR_CONTROL) begin
                    ctrl_q <= wrData & `CGIRQ_WMASK_CONTROL;
                end
            end
        end
    end

    // Read decode; status, state and latch ignore writes, unmapped read zero
    always @* begin
        if (regAddr == `CGIRQ_ADDR_LATCH) begin
            rdData = latch_q;
        end else if (regAddr == `CGIRQ_ADDR_MASK) begin
            rdData = mask_q;
        end else if (regAddr == `CGIRQ_ADDR_STATUS) begin
            rdData = status;
        end else if (regAddr == `CGIRQ_ADDR_STATE) begin
            rdData = {4'h0, stateCode};
        end else if (regAddr == `CGIRQ_ADDR_CONTROL) begin
            rdData = ctrl_q;
        end else begin
            rdData = 8'h00;
        end
    end

    // Control fields out to the analogue charger
    assign chargerEnable_n   = ctrl_q[`CGIRQ_CTL_ENABLE_N];
    assign trickleForce      = ctrl_q[`CGIRQ_CTL_TRICKLE];
    assign watchdogEnable    = ctrl_q[`CGIRQ_CTL_WATCHDOG];
    assign stateUpdateSelect = ctrl_q[`CGIRQ_CTL_STSEL];
    assign controlUpper      = ctrl_q[7:5];
    assign chargerIrq        = irq_q;
endmodule

// [cgirq_top_asserts.sv]
`timescale 1ns/1ps
module cgirq_top_asserts (
    input logic       mclk,
    input logic       rst,
    input logic       ce,
    input logic       spiSclk,
    input logic       spiCs_n,
    input logic       spiMosi,
    input logic       spiMiso,
    input logic       spiMisoOe,
    input logic       batteryOvervoltage,
    input logic       temperatureFault,
    input logic       chargeComplete,
    input logic       inputPresent,
    input logic       batteryPresent,
    input logic       currentLimit,
    input logic       inputOvervoltage,
    input logic [3:0] chargerStateCode,
    input logic       chargerEnable_n,
    input logic       trickleForce,
    input logic       watchdogEnable,
    input logic       stateUpdateSelect,
    input logic [2:0] controlUpper,
    input logic       chargerIrq
);
    logic [3:0]  csIdle_q;
    logic [3:0]  chgAge_q;
    logic [10:0] inPrev_q;
    wire  [10:0] inNow = {batteryOvervoltage, temperatureFault, chargeComplete, inputPresent,
                          batteryPresent, currentLimit, inputOvervoltage, chargerStateCode};
    wire  [7:0]  ctlOut = {controlUpper, 1'b0, stateUpdateSelect, watchdogEnable, trickleForce,
                           chargerEnable_n};
    // Quiet-cycle counters; saturate so old history never wraps into a false cause
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            csIdle_q <= 4'hf;
            chgAge_q <= 4'hf;
            inPrev_q <= 11'h000;
        end else begin
            inPrev_q <= inNow;
            csIdle_q <= !spiCs_n ? 4'h0 : (csIdle_q == 4'hf ? csIdle_q : csIdle_q + 4'h1);
            chgAge_q <= (inNow != inPrev_q || !ce) ? 4'h0
                      : (chgAge_q == 4'hf ? chgAge_q : chgAge_q + 4'h1);
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_csIdle; spiCs_n [*5]; endsequence
    sequence s_csActive; !spiCs_n [*3]; endsequence
    property p_ctl_reset; $fell(rst) |-> ctlOut == 8'ha1 && !chargerIrq; endproperty
    a_ctl_reset: assert property (p_ctl_reset) else $error("control not at reset value");
    property p_ctl_by_write; $changed(ctlOut) |-> csIdle_q < 4'h6; endproperty
    a_ctl_by_write: assert property (p_ctl_by_write) else $error("control moved without write");
    property p_ctl_hold; csIdle_q > 4'h7 |=> $stable(ctlOut); endproperty
    a_ctl_hold: assert property (p_ctl_hold) else $error("control drifted while idle");
    property p_irq_cause; $rose(chargerIrq) |-> chgAge_q < 4'h8 || csIdle_q < 4'h8; endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq rose without cause");
    property p_irq_clear; $fell(chargerIrq) |-> csIdle_q < 4'h8; endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("irq fell without access");
    property p_irq_quiet; csIdle_q == 4'hf && chgAge_q == 4'hf |=> $stable(chargerIrq); endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("irq moved while quiet");
    property p_oe_idle; s_csIdle |-> !spiMisoOe && !spiMiso; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("miso driven while deselected");
    property p_oe_active; s_csActive |-> spiMisoOe; endproperty
    a_oe_active: assert property (p_oe_active) else $error("miso not driven while selected");
endmodule

bind cgirq_top cgirq_top_asserts i_cgirq_top_asserts (.mclk(mclk), .rst(rst), .ce(ce),
    .spiSclk(spiSclk), .spiCs_n(spiCs_n), .spiMosi(spiMosi), .spiMiso(spiMiso),
    .spiMisoOe(spiMisoOe), .batteryOvervoltage(batteryOvervoltage),
    .temperatureFault(temperatureFault), .chargeComplete(chargeComplete),
    .inputPresent(inputPresent), .batteryPresent(batteryPresent), .currentLimit(currentLimit),
    .inputOvervoltage(inputOvervoltage), .chargerStateCode(chargerStateCode),
    .chargerEnable_n(chargerEnable_n), .trickleForce(trickleForce),
    .watchdogEnable(watchdogEnable), .stateUpdateSelect(stateUpdateSelect),
    .controlUpper(controlUpper), .chargerIrq(chargerIrq));

// [cgirq_top_tb.sv]
`timescale 1ns/1ps
module cgirq_top_tb;
    reg        mclk = 1'b0;
    reg        rst = 1'b1;
    reg        ce = 1'b1;
    reg        sclk = 1'b0;
    reg        csN = 1'b1;
    reg        mosi = 1'b0;
    reg  [7:0] cond = 8'h00;
    reg  [3:0] code = 4'h0;
    reg  [7:0] rd;
    wire       miso;
    wire       enN;
    wire       trk;
    wire       wdg;
    wire       sel;
    wire       irq;
    wire [2:0] upper;
    wire [7:0] ctlOut = {upper, 1'b0, sel, wdg, trk, enN};
    integer    failures = 0;
    integer    comparisons = 0;
    integer    i;

    // Clock enable dropped once to check that a new condition raises no interrupt until it returns
    cgirq_top i_cgirq_top (.mclk(mclk), .rst(rst), .ce(ce), .spiSclk(sclk), .spiCs_n(csN),
        .spiMosi(mosi), .spiMiso(miso), .spiMisoOe(), .batteryOvervoltage(cond[1]),
        .temperatureFault(cond[2]), .chargeComplete(cond[3]), .inputPresent(cond[4]),
        .batteryPresent(cond[5]), .currentLimit(cond[6]), .inputOvervoltage(cond[7]),
        .chargerStateCode(code), .chargerEnable_n(enN), .trickleForce(trk),
        .watchdogEnable(wdg), .stateUpdateSelect(sel), .controlUpper(upper), .chargerIrq(irq));

    always #20 mclk = ~mclk;

    task check(input [7:0] got, input [7:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("[FAIL] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask

    // One frame; sclk high for 6 mclk and low for 7 leaves the synchronisers ample margin
    task xfer(input w, input [7:0] a, input [7:0] d, output [7:0] q);
        reg [16:0] f;
        integer    k;
        begin
            f = {w, a, d};
            q = 8'h00;
            @(posedge mclk) csN <= 1'b0;
            for (k = 16; k >= 0; k = k - 1) begin
                @(posedge mclk) mosi <= f[k];
                repeat (6) @(posedge mclk);
                sclk <= 1'b1;
                if (k < 8) q[k] = miso;
                repeat (6) @(posedge mclk);
                sclk <= 1'b0;
            end
            repeat (6) @(posedge mclk);
            csN <= 1'b1;
            repeat (8) @(posedge mclk);
        end
    endtask

    task wr(input [7:0] a, input [7:0] d);
        xfer(1'b1, a, d, rd);
    endtask

    task rdc(input [7:0] a, input [7:0] exp);
        begin
            xfer(1'b0, a, 8'h00, rd);
            check(rd, exp);
        end
    endtask

    task settle;
        repeat (8) @(posedge mclk);
    endtask

    task end_of_test;
        begin
            $display("comparisons %0d failures %0d", comparisons, failures);
            if (failures == 0 && comparisons > 0) begin
                $display("verification passed");
            end else begin
                $display("verification failed");
            end
            $finish;
        end
    endtask

    // Hang guard: the sequence needs roughly 12300 cycles
    initial begin
        repeat (60000) @(posedge mclk);
        failures = failures + 1;
        end_of_test;
    end

    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        repeat (6) @(posedge mclk);
        check(ctlOut, 8'ha1);
        for (i = 0; i < 5; i = i + 1) begin
            rdc(8'hd0 + i[7:0], (i == 4) ? 8'ha1 : 8'h00);
        end
        $display("test reset values done");
        for (i = 0; i < 2; i = i + 1) begin
            wr(8'hd4, i ? 8'h00 : 8'hff);
            rdc(8'hd4, i ? 8'h00 : 8'hef);
            check(ctlOut, i ? 8'h00 : 8'hef);
        end
        wr(8'hd1, 8'hff);
        rdc(8'hd1, 8'hfe);
        wr(8'hd2, 8'hff);
        rdc(8'hd2, 8'h00);
        rdc(8'h55, 8'h00);
        $display("test control and mask done");
        // Walk one condition at a time with everything masked
        for (i = 1; i < 8; i = i + 1) begin
            cond <= 8'h01 << i;
            settle;
            rdc(8'hd2, 8'h01 << i);
            check({7'h00, irq}, 8'h00);
        end
        cond <= 8'h00;
        wr(8'hd1, 8'h00);
        check({7'h00, irq}, 8'h01);
        rdc(8'hd0, 8'hfe);
        settle;
        check({7'h00, irq}, 8'h00);
        rdc(8'hd0, 8'h00);
        cond <= 8'h30;
        settle;
        rdc(8'hd0, 8'h30);
        cond <= 8'h00;
        settle;
        rdc(8'hd0, 8'h30);
        rdc(8'hd2, 8'h00);
        $display("test conditions and latch done");
        for (i = 0; i < 16; i = i + 1) begin
            code <= i[3:0];
            settle;
            rdc(8'hd3, {4'h0, i[3:0]});
        end
        rdc(8'hd0, 8'h00);
        wr(8'hd4, 8'h08);
        code <= 4'h5;
        settle;
        check({7'h00, irq}, 8'h01);
        rdc(8'hd2, 8'h08);
        rdc(8'hd2, 8'h00);
        rdc(8'hd0, 8'h08);
        wr(8'hd1, 8'h08);
        code <= 4'h6;
        settle;
        check({7'h00, irq}, 8'h00);
        rdc(8'hd0, 8'h08);
        $display("test state code done");
        ce <= 1'b0;
        cond <= 8'h02;
        settle;
        check({7'h00, irq}, 8'h00);
        ce <= 1'b1;
        settle;
        check({7'h00, irq}, 8'h01);
        rdc(8'hd0, 8'h02);
        $display("test clock enable done");
        end_of_test;
    end
endmodule
